// ---- rtl/wer_router.sv ----
// Module: wake-up event router top with register port and reset pin filter
// What this block does
// - Merges wake pins, timekeeping events and peripheral lines into one interrupt request, for enabled events only.
// - Drives a wake-up request to the core and the clock control unit out of every reduced-power mode.
// - Each event has its own bit choosing edge or level detection.
// - Each event has its own enable, and a disabled event raises neither wake nor interrupt.
// - Wake pins, reset pin, alarm and real-time clock events wake from all four modes, the real-time clock event only with the 32 kHz oscillator running.
// - Watchdog, brown-out, CAN, quadrature, Ethernet, USB and timer events wake from sleep only.
// - Any interrupt enabled in the interrupt controller wakes the core from sleep regardless of the router enables.
// - Each peripheral reaches the interrupt controller on exactly one line that may merge several flags.
// - A low pulse of at least 50 ns on the reset pin resets the device so fetch restarts at address 0.
`timescale 1ns/10ps
module wer_router (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic [wer_pkg::NUM_PIN-1:0] i_external_wake_pin,
  input wire logic i_reset_pin_n,
  input wire logic i_alarm_evt,
  input wire logic i_rtc_evt,
  input wire logic i_osc32k_running,
  input wire logic [wer_pkg::NUM_PERIPH-1:0] i_periph_irq,
  input wire logic i_nested_vector_irq_ctrl_pending_enabled,
  input wire logic [2:0] i_power_mode,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_irq,
  output logic o_wake_core,
  output logic o_wake_clock_control_unit,
  output logic o_device_reset
);
  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [wer_pkg::NUM_EVT-1:0] enable;
  logic [wer_pkg::NUM_EVT-1:0] edge_cfg;
  logic [wer_pkg::NUM_EVT-1:0] irq_mask;
  logic [31:0] rdata;
  logic [wer_pkg::RST_CNT_W-1:0] rst_cnt;
  logic dev_rst;
  logic irq_q;
  logic wake_q;

  wer_evt_if evt ();

  // ----------------------------------------------------------------
  // Event collection
  // ----------------------------------------------------------------
  wire rtc_gated = i_rtc_evt & i_osc32k_running;
  // Reset pin events by its low level; each peripheral is one line
  wire [wer_pkg::NUM_EVT-1:0] raw_evt = {i_periph_irq, rtc_gated, i_alarm_evt, ~i_reset_pin_n,
                                         i_external_wake_pin};
  assign evt.raw = raw_evt;
  assign evt.edge_sel = edge_cfg;

  wer_detect u_detect (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .evt(evt)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire sel_enable = i_addr == wer_pkg::OFS_ENABLE;
  wire sel_edge = i_addr == wer_pkg::OFS_EDGE;
  wire sel_status = i_addr == wer_pkg::OFS_STATUS;
  wire sel_mask = i_addr == wer_pkg::OFS_MASK;
  wire sel_raw = i_addr == wer_pkg::OFS_RAW;
  wire sel_mode = i_addr == wer_pkg::OFS_MODE;
  wire wr_enable = i_wr & sel_enable;
  wire wr_edge = i_wr & sel_edge;
  wire wr_mask = i_wr & sel_mask;
  // Write one to clear; only edge flags are sticky
  assign evt.clr = (i_wr & sel_status) ? i_wdata[wer_pkg::NUM_EVT-1:0] : '0;

  // ----------------------------------------------------------------
  // Request logic
  // ----------------------------------------------------------------
  wire [wer_pkg::NUM_EVT-1:0] active = evt.hit & enable;
  wire [wer_pkg::NUM_EVT-1:0] status_view = evt.hit;
  wire next_irq = |(active & irq_mask);
  wire in_deep = i_power_mode != 3'(wer_pkg::WER_RUN) && i_power_mode != 3'(wer_pkg::WER_SLEEP);
  // Deeper modes accept only the always-on events
  wire [wer_pkg::NUM_EVT-1:0] wake_ok = in_deep ? wer_pkg::ALL_MODE_MASK : '1;
  wire in_sleep = i_power_mode == 3'(wer_pkg::WER_SLEEP);
  wire next_wake = (|(active & wake_ok)) | (in_sleep & i_nested_vector_irq_ctrl_pending_enabled);

  // Short glitches on the reset pin are ignored by the counter
  wire pin_low = ~i_reset_pin_n;
  wire cnt_full = rst_cnt == wer_pkg::RST_CNT_MAX;
  wire [wer_pkg::RST_CNT_W-1:0] next_rst_cnt = !pin_low ? wer_pkg::RST_CNT_ZERO :
                                              cnt_full ? rst_cnt : rst_cnt + wer_pkg::RST_CNT_ONE;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  wire [31:0] next_rdata = sel_enable ? {16'h0000, enable} :
                           sel_edge ? {16'h0000, edge_cfg} :
                           sel_status ? {16'h0000, status_view} :
                           sel_mask ? {16'h0000, irq_mask} :
                           sel_raw ? {16'h0000, evt.sample} :
                           sel_mode ? {29'h0000_0000, i_power_mode} :
                           wer_pkg::ZERO_WORD;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      enable <= wer_pkg::RST_ENABLE;
      edge_cfg <= wer_pkg::RST_EDGE;
      irq_mask <= wer_pkg::RST_MASK;
    end else begin
      if (wr_enable) begin
        enable <= i_wdata[wer_pkg::NUM_EVT-1:0];
      end
      if (wr_edge) begin
        edge_cfg <= i_wdata[wer_pkg::NUM_EVT-1:0];
      end
      if (wr_mask) begin
        irq_mask <= i_wdata[wer_pkg::NUM_EVT-1:0];
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdata <= wer_pkg::ZERO_WORD;
      irq_q <= 1'b0;
      wake_q <= 1'b0;
      rst_cnt <= wer_pkg::RST_CNT_ZERO;
      dev_rst <= 1'b0;
    end else begin
      rdata <= i_rd ? next_rdata : wer_pkg::ZERO_WORD;
      irq_q <= next_irq;
      wake_q <= next_wake;
      rst_cnt <= next_rst_cnt;
      dev_rst <= pin_low & (cnt_full | next_rst_cnt == wer_pkg::RST_CNT_MAX);
    end
  end

  assign o_rdata = rdata;
  assign o_irq = irq_q;
  assign o_wake_core = wake_q;
  assign o_wake_clock_control_unit = wake_q;
  assign o_device_reset = dev_rst;
endmodule : wer_router

// ---- rtl/wer_pkg.sv ----
// Package: constants, event map and power modes for the wake-up event router
package wer_pkg;
  // Event bit positions
  localparam int unsigned NUM_EVT = 16;
  localparam int unsigned EV_PIN0 = 0;
  localparam int unsigned EV_RESET = 4;
  localparam int unsigned EV_ALARM = 5;
  localparam int unsigned EV_RTC = 6;
  localparam int unsigned EV_FIRST_SLEEP_ONLY = 7;
  localparam int unsigned NUM_PIN = 4;
  localparam int unsigned NUM_PERIPH = 9;
  // Bit set: event may wake from every reduced-power mode
  localparam logic [NUM_EVT-1:0] ALL_MODE_MASK = 16'h007F;
  // Register offsets
  localparam logic [7:0] OFS_ENABLE = 8'h00;
  localparam logic [7:0] OFS_EDGE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0C;
  localparam logic [7:0] OFS_RAW = 8'h10;
  localparam logic [7:0] OFS_MODE = 8'h14;
  // Reset values
  localparam logic [NUM_EVT-1:0] RST_ENABLE = 16'h0000;
  localparam logic [NUM_EVT-1:0] RST_EDGE = 16'h0000;
  localparam logic [NUM_EVT-1:0] RST_MASK = 16'h0000;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  // Reset pin filter: 50 ns at 200 MHz, least time rounded up
  localparam int unsigned RST_PULSE_NS = 50;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_CNT_W = 4;
  localparam logic [RST_CNT_W-1:0] RST_CNT_MAX = RST_CNT_W'(RST_PULSE_CYC);
  localparam logic [RST_CNT_W-1:0] RST_CNT_ONE = 4'h1;
  localparam logic [RST_CNT_W-1:0] RST_CNT_ZERO = 4'h0;
  typedef enum logic [1:0] {
    WER_RUN,
    WER_SLEEP,
    WER_DEEP_SLEEP,
    WER_POWER_DOWN
  } wer_pmode_t;
  localparam logic [2:0] MODE_DEEP_PD = 3'h4;
endpackage : wer_pkg

// ---- rtl/wer_evt_if.sv ----
// Interface: event lines between router top and its detector core
`timescale 1ns/10ps
interface wer_evt_if;
  logic [wer_pkg::NUM_EVT-1:0] raw;
  logic [wer_pkg::NUM_EVT-1:0] edge_sel;
  logic [wer_pkg::NUM_EVT-1:0] clr;
  logic [wer_pkg::NUM_EVT-1:0] hit;
  logic [wer_pkg::NUM_EVT-1:0] sample;
  modport top (output raw, output edge_sel, output clr, input hit, input sample);
  modport det (input raw, input edge_sel, input clr, output hit, output sample);
endinterface : wer_evt_if

// ---- rtl/wer_detect.sv ----
// Module: per-event edge or level detector with sticky flags
`timescale 1ns/10ps
module wer_detect (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  wer_evt_if.det evt
);
  logic [wer_pkg::NUM_EVT-1:0] prev;
  logic [wer_pkg::NUM_EVT-1:0] flag;
  genvar g;
  generate
    for (g = 0; g < wer_pkg::NUM_EVT; g++) begin : g_evt
      wire rise = evt.raw[g] & ~prev[g];
      // Set wins over clear so a same-cycle event is kept
      wire next_flag = rise | (flag[g] & ~evt.clr[g]);
      always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          prev[g] <= 1'b0;
          flag[g] <= 1'b0;
        end else begin
          prev[g] <= evt.raw[g];
          flag[g] <= next_flag;
        end
      end
      // Level mode follows the input live; edge mode holds the flag
      assign evt.hit[g] = evt.edge_sel[g] ? flag[g] : evt.raw[g];
    end
  endgenerate
  assign evt.sample = prev;
endmodule : wer_detect

// ---- tb/wer_nested_vector_irq_ctrl_model.sv ----
// Partner: interrupt controller side with other enabled sources
`timescale 1ns/10ps
module wer_nested_vector_irq_ctrl_model (
  input wire logic i_src,
  input wire logic i_src_en,
  output logic o_pending_enabled
);
  // Source enabled here only, never in the router
  assign o_pending_enabled = i_src & i_src_en;
endmodule : wer_nested_vector_irq_ctrl_model

// ---- tb/wer_router_asserts.sv ----
// Checker: port assertions for the wake-up event router
`timescale 1ns/10ps
module wer_router_asserts (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic [wer_pkg::NUM_PIN-1:0] i_external_wake_pin,
  input wire logic i_reset_pin_n,
  input wire logic i_alarm_evt,
  input wire logic i_rtc_evt,
  input wire logic i_osc32k_running,
  input wire logic [wer_pkg::NUM_PERIPH-1:0] i_periph_irq,
  input wire logic i_nested_vector_irq_ctrl_pending_enabled,
  input wire logic [2:0] i_power_mode,
  input wire logic [7:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic o_irq,
  input wire logic o_wake_core,
  input wire logic o_wake_clock_control_unit,
  input wire logic o_device_reset
);
  wire logic [16:0] cause = {i_osc32k_running, i_periph_irq, i_rtc_evt, i_alarm_evt, i_reset_pin_n, i_external_wake_pin};
  // Three-deep history covers edge path latency
  logic [2:0] chg;
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      // Reset itself may drop outputs, so it counts as a cause
      chg <= 3'h7;
    end else begin
      chg <= {chg[1:0], $changed(cause) | i_wr};
    end
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  property p_rd_idle; !$past(i_rd) |-> o_rdata == 32'h0000_0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not zero");
  property p_rd_mode; i_rd && i_addr == wer_pkg::OFS_MODE |=> o_rdata == {29'h0, $past(i_power_mode)}; endproperty
  a_rd_mode: assert property (p_rd_mode) else $error("mode read wrong");
  property p_wake_pair; o_wake_core == o_wake_clock_control_unit; endproperty
  a_wake_pair: assert property (p_wake_pair) else $error("wake outputs differ");
  property p_irq_cause; $rose(o_irq) |-> |chg; endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq rose without cause");
  property p_irq_hold; $fell(o_irq) |-> |chg; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq fell without cause");
  property p_wake_nested_vector_irq_ctrl; (i_power_mode == 3'h1 && i_nested_vector_irq_ctrl_pending_enabled)[*2] |-> o_wake_core; endproperty
  a_wake_nested_vector_irq_ctrl: assert property (p_wake_nested_vector_irq_ctrl) else $error("no wake from sleep");
  property p_rst_long; (!i_reset_pin_n)[*8] ##1 (!i_reset_pin_n)[*4] |-> o_device_reset; endproperty
  a_rst_long: assert property (p_rst_long) else $error("reset pin ignored");
  property p_rst_end; i_reset_pin_n[*2] |-> !o_device_reset; endproperty
  a_rst_end: assert property (p_rst_end) else $error("reset held too long");
endmodule : wer_router_asserts
bind wer_router wer_router_asserts u_chk (.i_clk_sys, .i_sys_rst, .i_external_wake_pin, .i_reset_pin_n, .i_alarm_evt,
  .i_rtc_evt, .i_osc32k_running, .i_periph_irq, .i_nested_vector_irq_ctrl_pending_enabled, .i_power_mode, .i_addr, .i_wr, .i_rd,
  .o_rdata, .o_irq, .o_wake_core, .o_wake_clock_control_unit, .o_device_reset);

// ---- tb/tb_wer_router.sv ----
// Testbench: directed scenarios for the wake-up event router
`timescale 1ns/10ps
module tb_wer_router;
  logic i_clk_sys = 1'b0, i_sys_rst = 1'b1, i_reset_pin_n = 1'b1, i_alarm_evt = 1'b0, i_rtc_evt = 1'b0;
  logic i_osc32k_running = 1'b0, i_wr = 1'b0, i_rd = 1'b0, src = 1'b0, src_en = 1'b0, i_nested_vector_irq_ctrl_pending_enabled;
  logic [3:0] i_external_wake_pin = 4'h0;
  logic [8:0] i_periph_irq = 9'h000;
  logic [2:0] i_power_mode = 3'h0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000, o_rdata;
  logic o_irq, o_wake_core, o_wake_clock_control_unit, o_device_reset;
  int n_errors = 0;
  int comparisons = 0;
  always #2.5 i_clk_sys = ~i_clk_sys;
  wer_router DUT (.i_clk_sys, .i_sys_rst, .i_external_wake_pin, .i_reset_pin_n, .i_alarm_evt, .i_rtc_evt,
    .i_osc32k_running, .i_periph_irq, .i_nested_vector_irq_ctrl_pending_enabled, .i_power_mode, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .o_irq, .o_wake_core, .o_wake_clock_control_unit, .o_device_reset);
  wer_nested_vector_irq_ctrl_model u_nested_vector_irq_ctrl (.i_src(src), .i_src_en(src_en), .o_pending_enabled(i_nested_vector_irq_ctrl_pending_enabled));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %0h seen %0h", n, e, s);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys) {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_clk_sys) i_wr <= 1'b0;
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk_sys) {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_clk_sys) i_rd <= 1'b0;
    #1 chk("rdata", e, o_rdata);
  endtask : rc
  task automatic s_regs();
    for (int a = 0; a <= 20; a += 4) rc(8'(a), 32'h0000_0000);
    wr(8'h40, 32'h0000_FFFF);
    rc(8'h40, 32'h0000_0000);
  endtask : s_regs
  task automatic s_edge();
    wr(wer_pkg::OFS_ENABLE, 32'h0000_0001);
    wr(wer_pkg::OFS_EDGE, 32'h0000_0001);
    wr(wer_pkg::OFS_MASK, 32'h0000_0001);
    rc(wer_pkg::OFS_EDGE, 32'h0000_0001);
    rc(wer_pkg::OFS_ENABLE, 32'h0000_0001);
    @(posedge i_clk_sys) i_external_wake_pin <= 4'h1;
    @(posedge i_clk_sys) i_external_wake_pin <= 4'h0;
    step(8);
    chk("irq", 1, o_irq);
    rc(wer_pkg::OFS_STATUS, 32'h0000_0001);
    wr(wer_pkg::OFS_STATUS, 32'h0000_0001);
    step(2);
    chk("irq", 0, o_irq);
    rc(wer_pkg::OFS_STATUS, 32'h0000_0000);
  endtask : s_edge
  task automatic s_level();
    wr(wer_pkg::OFS_ENABLE, 32'h0000_0020);
    wr(wer_pkg::OFS_EDGE, 32'h0000_0000);
    wr(wer_pkg::OFS_MASK, 32'h0000_00A0);
    @(posedge i_clk_sys) i_alarm_evt <= 1'b1;
    step(3);
    chk("irq", 1, o_irq);
    @(posedge i_clk_sys) i_alarm_evt <= 1'b0;
    step(3);
    chk("irq", 0, o_irq);
    wr(wer_pkg::OFS_ENABLE, 32'h0000_0000);
    @(posedge i_clk_sys) {i_alarm_evt, i_power_mode} <= {1'b1, 3'h1};
    step(3);
    chk("wake", 0, o_wake_core);
    chk("irq", 0, o_irq);
  endtask : s_level
  task automatic s_modes();
    wr(wer_pkg::OFS_ENABLE, 32'h0000_00C0);
    @(posedge i_clk_sys) {i_alarm_evt, i_periph_irq, i_power_mode} <= {1'b0, 9'h001, 3'h2};
    step(3);
    chk("wake", 0, o_wake_core);
    @(posedge i_clk_sys) i_power_mode <= 3'h1;
    step(3);
    chk("wake", 1, o_wake_clock_control_unit);
    chk("irq", 1, o_irq);
    rc(wer_pkg::OFS_MODE, 32'h0000_0001);
    rc(wer_pkg::OFS_RAW, 32'h0000_0080);
    @(posedge i_clk_sys) {i_periph_irq, i_rtc_evt} <= {9'h000, 1'b1};
    for (int m = 1; m <= 5; m++) begin
      @(posedge i_clk_sys) {i_power_mode, i_osc32k_running} <= {3'(m % 5), m < 5};
      step(3);
      chk("wake", m < 5, o_wake_core);
    end
    @(posedge i_clk_sys) i_rtc_evt <= 1'b0;
  endtask : s_modes
  task automatic s_nested_vector_irq_ctrl();
    wr(wer_pkg::OFS_ENABLE, 32'h0000_0000);
    @(posedge i_clk_sys) {src, src_en, i_power_mode} <= {2'h3, 3'h1};
    step(3);
    chk("wake", 1, o_wake_core);
    @(posedge i_clk_sys) i_power_mode <= 3'h2;
    step(3);
    chk("wake", 0, o_wake_core);
    @(posedge i_clk_sys) {src, i_power_mode} <= {1'b0, 3'h0};
  endtask : s_nested_vector_irq_ctrl
  task automatic s_pin();
    @(posedge i_clk_sys) i_reset_pin_n <= 1'b0;
    repeat (10) @(posedge i_clk_sys);
    i_reset_pin_n <= 1'b1;
    #1 chk("dev_reset", 1, o_device_reset);
    step(2);
    chk("dev_reset", 0, o_device_reset);
    @(posedge i_clk_sys) i_reset_pin_n <= 1'b0;
    step(12);
    chk("dev_reset", 1, o_device_reset);
    @(posedge i_clk_sys) i_reset_pin_n <= 1'b1;
    step(3);
    chk("dev_reset", 0, o_device_reset);
  endtask : s_pin
  task automatic give_verdict();
    if (n_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    n_errors++;
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    s_regs();
    s_edge();
    s_level();
    s_modes();
    s_nested_vector_irq_ctrl();
    s_pin();
    wr(wer_pkg::OFS_ENABLE, 32'h0000_0010);
    @(posedge i_clk_sys) i_sys_rst <= 1'b1;
    @(posedge i_clk_sys) i_sys_rst <= 1'b0;
    s_regs();
    give_verdict();
  end
endmodule : tb_wer_router
